/* rtl/stage_irq_gate.v */
// per-stage interrupt enable gating, status flags and active-low interrupt output
//
// Operation
// - high enable bit n set and stage n above high threshold pulls interrupt low.
// - an enable bit at zero keeps its stage event off the interrupt output.
// - completion enable bit n set and stage n conversion done pulls interrupt low.
// - all high and completion enable bits read zero after reset.
// - stage n above high threshold sets bit n of the high-limit status register.
// - stage n conversion complete sets bit n of the completion status register.
// - status registers clear after host read unless the limit still holds.
`timescale 1ns/1ps
`include "stage_irq_map.vh"

// register port: a write lands at its strobe edge, read data follows one cycle later.
// interrupt: a flag sets at the event edge and the pin falls one edge after that.
// a status read clears its word; an event in the clearing cycle keeps its bit.
// unmapped addresses read zero and ignore writes.

module stage_irq_gate (
  input  wire                  sys_clk,
  input  wire                  arst_n,
  input  wire [`ADDR_W-1:0]    reg_addr,
  input  wire [`DATA_W-1:0]    reg_wdata,
  input  wire                  reg_wr,
  input  wire                  reg_rd,
  input  wire [`STAGE_N-1:0]   high_exceed,
  input  wire [`STAGE_N-1:0]   low_exceed,
  input  wire [`STAGE_N-1:0]   conv_done,
  input  wire [`STAGE_N-1:0]   low_irq_enable,
  output reg  [`DATA_W-1:0]    reg_rdata_r,
  output reg                   reg_rvalid_r,
  output reg  [`STAGE_N-1:0]   high_irq_enable_r,
  output reg  [`STAGE_N-1:0]   done_irq_enable_r,
  output reg                   int_n_r
);

  // reset release through two flops; assertion stays asynchronous
  reg rst_meta_r;
  reg rst_n_r;

  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_r <= 1'b0;
      rst_n_r    <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r    <= rst_meta_r;
    end
  end

  // address decode shared by the read and write paths
  function hit;
    input [`ADDR_W-1:0] addr;
    input [`ADDR_W-1:0] offset;
    begin
      hit = (addr == offset);
    end
  endfunction

  // enable bytes sit in the low lanes; the upper byte reads zero
  function [`DATA_W-1:0] widen;
    input [`STAGE_N-1:0] val;
    begin
      widen = {`UNUSED_READ, val};
    end
  endfunction

  wire wr_high_en;
  wire wr_done_en;
  wire rd_low;
  wire rd_high;
  wire rd_done;

  assign wr_high_en = reg_wr & hit(reg_addr, `OFF_HIGH_IRQ_EN);
  assign wr_done_en = reg_wr & hit(reg_addr, `OFF_DONE_IRQ_EN);
  assign rd_low     = reg_rd & hit(reg_addr, `OFF_LOW_LIMIT_FLAG);
  assign rd_high    = reg_rd & hit(reg_addr, `OFF_HIGH_LIMIT_FLAG);
  assign rd_done    = reg_rd & hit(reg_addr, `OFF_DONE_FLAG);

  // enable registers; upper byte is not stored, so a stray one there has no effect
  reg [`STAGE_N-1:0] high_irq_enable_nxt;
  reg [`STAGE_N-1:0] done_irq_enable_nxt;

  always @* begin
    high_irq_enable_nxt = high_irq_enable_r;
    if (wr_high_en) begin
      high_irq_enable_nxt = reg_wdata[`EN_FIELD_MSB:`EN_FIELD_LSB];
    end
  end

  always @* begin
    done_irq_enable_nxt = done_irq_enable_r;
    if (wr_done_en) begin
      done_irq_enable_nxt = reg_wdata[`EN_FIELD_MSB:`EN_FIELD_LSB];
    end
  end

  always @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      high_irq_enable_r <= `RST_IRQ_EN;
    end else begin
      high_irq_enable_r <= high_irq_enable_nxt;
    end
  end

  always @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      done_irq_enable_r <= `RST_IRQ_EN;
    end else begin
      done_irq_enable_r <= done_irq_enable_nxt;
    end
  end

  // sticky status flags
  wire [`STAGE_N-1:0] low_limit_flag;
  wire [`STAGE_N-1:0] stage_high_limit_flag;
  wire [`STAGE_N-1:0] stage_conversion_done_flag;

  stage_flag_bank u_low_flags (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n_r),
    .set_evt  (low_exceed),
    .read_clr (rd_low),
    .flag_r   (low_limit_flag)
  );

  stage_flag_bank u_high_flags (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n_r),
    .set_evt  (high_exceed),
    .read_clr (rd_high),
    .flag_r   (stage_high_limit_flag)
  );

  stage_flag_bank u_done_flags (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n_r),
    .set_evt  (conv_done),
    .read_clr (rd_done),
    .flag_r   (stage_conversion_done_flag)
  );

  // read mux; data returned one cycle after the request, unmapped reads give zero
  reg [`DATA_W-1:0] reg_rdata_nxt;

  always @* begin
    reg_rdata_nxt = `RST_RDATA;
    case (reg_addr)
      `OFF_HIGH_IRQ_EN:     reg_rdata_nxt = widen(high_irq_enable_r);
      `OFF_DONE_IRQ_EN:     reg_rdata_nxt = widen(done_irq_enable_r);
      `OFF_LOW_LIMIT_FLAG:  reg_rdata_nxt = widen(low_limit_flag);
      `OFF_HIGH_LIMIT_FLAG: reg_rdata_nxt = widen(stage_high_limit_flag);
      `OFF_DONE_FLAG:       reg_rdata_nxt = widen(stage_conversion_done_flag);
      default:              reg_rdata_nxt = `RST_RDATA;
    endcase
  end

  always @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      reg_rvalid_r <= 1'b0;
    end else begin
      reg_rvalid_r <= reg_rd;
    end
  end

  // data holds between reads so a slow host can still pick it up
  always @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      reg_rdata_r <= `RST_RDATA;
    end else if (reg_rd) begin
      reg_rdata_r <= reg_rdata_nxt;
    end
  end

  // interrupt gating: a source reaches the pin only through its enable bit
  function [`STAGE_N-1:0] gate_src;
    input [`STAGE_N-1:0] flags;
    input [`STAGE_N-1:0] enables;
    begin
      gate_src = flags & enables;
    end
  endfunction

  wire [`STAGE_N-1:0] high_src;
  wire [`STAGE_N-1:0] done_src;
  wire [`STAGE_N-1:0] low_src;
  wire                high_any;
  wire                done_any;
  wire                low_any;
  wire                irq_any;

  assign high_src = gate_src(stage_high_limit_flag, high_irq_enable_r);
  assign done_src = gate_src(stage_conversion_done_flag, done_irq_enable_r);
  assign low_src  = gate_src(low_limit_flag, low_irq_enable);
  assign high_any = |high_src;
  assign done_any = |done_src;
  assign low_any  = |low_src;
  // the pin follows the sticky flags, so it stays low until the host reads status
  assign irq_any  = high_any | done_any | low_any;

  reg int_n_nxt;

  always @* begin
    int_n_nxt = 1'b1;
    if (irq_any) begin
      int_n_nxt = 1'b0;
    end
  end

  always @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      int_n_r <= 1'b1;
    end else begin
      int_n_r <= int_n_nxt;
    end
  end

endmodule

/* rtl/stage_irq_map.vh */
// register offsets, field layout, reset values for the stage interrupt gating block
`ifndef STAGE_IRQ_MAP_VH
`define STAGE_IRQ_MAP_VH

`define ADDR_W               10
`define DATA_W               16
`define STAGE_N              8

`define OFF_HIGH_IRQ_EN      10'h006
`define OFF_DONE_IRQ_EN      10'h007
`define OFF_LOW_LIMIT_FLAG   10'h008
`define OFF_HIGH_LIMIT_FLAG  10'h009
`define OFF_DONE_FLAG        10'h00a

`define EN_FIELD_LSB         0
`define EN_FIELD_MSB         7
`define UNUSED_FIELD_LSB     8
`define UNUSED_FIELD_MSB     15

`define RST_IRQ_EN           8'h00
`define RST_FLAGS            8'h00
`define RST_RDATA            16'h0000
`define UNUSED_READ          8'h00

`endif

/* rtl/stage_flag_bank.v */
// eight sticky per-stage status flags, cleared by a host read unless the cause persists
`timescale 1ns/1ps
`include "stage_irq_map.vh"

module stage_flag_bank (
  input  wire                  sys_clk,
  input  wire                  rst_n,
  input  wire [`STAGE_N-1:0]   set_evt,
  input  wire                  read_clr,
  output reg  [`STAGE_N-1:0]   flag_r
);

  reg [`STAGE_N-1:0] flag_nxt;

  // a set in the same cycle as the read clear wins, so a held limit keeps its bit
  always @* begin
    flag_nxt = (read_clr ? `RST_FLAGS : flag_r) | set_evt;
  end

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_r <= `RST_FLAGS;
    end else begin
      flag_r <= flag_nxt;
    end
  end

endmodule

/* verification/stage_irq_gate_monitor.sv */
// assertions on the stage interrupt gating ports
`timescale 1ns/1ps
module stage_irq_gate_monitor (
  input sys_clk,
  input arst_n,
  input [9:0] reg_addr,
  input reg_wr,
  input reg_rd,
  input [7:0] high_exceed,
  input [7:0] conv_done,
  input [7:0] low_irq_enable,
  input [15:0] reg_rdata_r,
  input [7:0] high_irq_enable_r,
  input [7:0] done_irq_enable_r,
  input int_n_r
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  wire [7:0] he = high_irq_enable_r, de = done_irq_enable_r, q = reg_rdata_r[7:0];
  wire rh = reg_rd && reg_addr==10'h009, rc = reg_rd && reg_addr==10'h00a;
  hi_irq_a: assert property ((high_exceed&he)!=0 && !reg_wr |=> ##1 !int_n_r)
    else $error("high irq lost");
  off_quiet_a: assert property (he==0 && de==0 && low_irq_enable==0 |=> int_n_r)
    else $error("irq while off");
  done_irq_a: assert property ((conv_done&de)!=0 && !reg_wr |-> ##2 !int_n_r)
    else $error("done irq lost");
  rst_en_a: assert property ($rose(arst_n) |-> he==0 && de==0)
    else $error("enable not reset");
  fall_cause_a: assert property ($fell(int_n_r) |-> $past(he|de|low_irq_enable)!=0)
    else $error("irq without cause");
  hi_flag_a: assert property (high_exceed!=0 ##1 (!rh) [*5] ##1 rh |=>
    (q&$past(high_exceed, 7))==$past(high_exceed, 7)) else $error("high flag lost");
  done_flag_a: assert property (conv_done!=0 ##1 (!rc) [*3] ##1 rc |=>
    (q&$past(conv_done, 5))==$past(conv_done, 5)) else $error("done flag lost");
  rd_clear_a: assert property (rc && conv_done==0 ##1 conv_done==0 ##1 rc |=> q==0)
    else $error("flag kept");
  cover property (!int_n_r);
  cover property (rc ##2 rc);
  cover property ($rose(int_n_r));
endmodule

bind stage_irq_gate stage_irq_gate_monitor chk_u (.*);

/* verification/host_bfm.sv */
// host model issuing register writes and reads
`timescale 1ns/1ps
module host_bfm (
  input sys_clk,
  input [15:0] reg_rdata_r,
  output logic [9:0] reg_addr = 0,
  output logic [15:0] reg_wdata = 0,
  output logic reg_wr = 0,
  output logic reg_rd = 0
);
  task acc(input w, input [9:0] a, input [7:0] d, output [15:0] q);
    @(posedge sys_clk) {reg_addr, reg_wdata, reg_wr, reg_rd} <= {a, 8'h00, d, w, !w};
    @(posedge sys_clk) {reg_wdata, reg_wr, reg_rd} <= {~reg_wdata, 2'b00};
    #1 q = reg_rdata_r;
  endtask
endmodule

/* verification/stage_irq_gate_tb.sv */
// self-checking bench for the stage interrupt gating block
`timescale 1ns/1ps
module stage_irq_gate_tb;
  logic sys_clk = 0, arst_n = 0, reg_wr, reg_rd, reg_rvalid_r, int_n_r;
  logic [9:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata_r, q;
  logic [7:0] high_exceed = 0, low_exceed = 0, conv_done = 0, low_irq_enable = 0, e, f, h, r, l;
  logic [7:0] m_hen, m_den, m_hf, m_df, m_lf;
  logic [15:0] exp_q[$];
  logic [7:0] high_irq_enable_r, done_irq_enable_r;
  int miscompares = 0, n_tests = 0;
  always #50 sys_clk = ~sys_clk;
  host_bfm host_u(.*);
  stage_irq_gate dut_u(.*);
  task chk_word(input [15:0] g, input [15:0] x);
    n_tests++;
    if (g !== x) begin
      miscompares++;
      $display("ERROR %0t %h %h", $time, g, x);
    end
  endtask
  task chk_bit(input g, input x);
    n_tests++;
    if (g !== x) begin
      miscompares++;
      $display("ERROR %0t %h %h", $time, g, x);
    end
  endtask
  task rd(input [9:0] a, output [15:0] d);
    host_u.acc(0, a, 0, d);
    chk_bit(reg_rvalid_r, 1);
  endtask
  task wr(input [9:0] a, input [7:0] d);
    host_u.acc(1, a, d, q);
  endtask
  task report_and_stop;
    $display("tests %0d errors %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    void'($urandom(32'h9a80));
    repeat (4) @(posedge sys_clk);
    arst_n <= 1;
    repeat (3) @(posedge sys_clk);
    for (int a = 6; a < 8; a++) begin
      rd(a, q);
      chk_word(q, 0);
    end
    {m_hen, m_den, m_hf, m_df, m_lf} = 0;
    low_irq_enable <= $urandom;
    repeat (12) begin
      {e, f, h, r} = $urandom;
      l = $urandom;
      wr(10'h006, e);
      m_hen = e;
      chk_word(high_irq_enable_r, m_hen);
      wr(10'h007, f);
      m_den = f;
      chk_word(done_irq_enable_r, m_den);
      @(posedge sys_clk) {high_exceed, low_exceed, conv_done} <= {h, l, r};
      @(posedge sys_clk) {high_exceed, low_exceed, conv_done} <= 0;
      m_hf = m_hf | h;
      m_lf = m_lf | l;
      m_df = m_df | r;
      exp_q.push_back({8'h00, m_df});
      exp_q.push_back({8'h00, m_hf});
      exp_q.push_back({8'h00, m_lf});
      repeat (2) @(posedge sys_clk);
      #1 chk_bit(int_n_r, ((m_hf & m_hen) | (m_df & m_den) | (m_lf & low_irq_enable)) == 0);
      chk_bit(reg_rvalid_r, 0);
      rd(10'h00a, q);
      chk_word(q, exp_q.pop_front());
      rd(10'h009, q);
      chk_word(q, exp_q.pop_front());
      rd(10'h008, q);
      chk_word(q, exp_q.pop_front());
      {m_hf, m_df, m_lf} = 0;
      rd(10'h006, q);
      chk_word(q, m_hen);
      rd(10'h007, q);
      chk_word(q, m_den);
      repeat (2) @(posedge sys_clk);
      #1 chk_bit(int_n_r, 1);
    end
    wr(10'h006, 8'h00);
    wr(10'h007, 8'h00);
    low_irq_enable <= 0;
    @(posedge sys_clk) {high_exceed, low_exceed, conv_done} <= 24'hffffff;
    @(posedge sys_clk) {high_exceed, low_exceed, conv_done} <= 0;
    repeat (2) @(posedge sys_clk);
    #1 chk_bit(int_n_r, 1);
    rd(10'h009, q);
    chk_word(q, 16'h00ff);
    rd(10'h00a, q);
    chk_word(q, 16'h00ff);
    rd(10'h008, q);
    chk_word(q, 16'h00ff);
    rd(10'h00a, q);
    rd(10'h00a, q);
    chk_word(q, 0);
    rd(10'h00b, q);
    chk_word(q, 0);
    wr(10'h006, 8'hff);
    wr(10'h007, 8'hff);
    @(posedge sys_clk) arst_n <= 0;
    repeat (2) @(posedge sys_clk);
    arst_n <= 1;
    repeat (3) @(posedge sys_clk);
    #1 chk_word(high_irq_enable_r, 0);
    chk_word(done_irq_enable_r, 0);
    chk_bit(int_n_r, 1);
    report_and_stop;
  end
endmodule
